// ===== dpa_pkg.sv
// Package for the dual-port RAM port host controller.
// Assumes a 20 MHz clock and an asynchronous dual-port RAM on the far side.
package dpa_pkg;
   localparam int CLK_NS = 50;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 8;
   // Write and read timing, ns as printed (fastest grade)
   localparam int WRITE_PULSE_NS = 12;
   localparam int OUTPUT_OFF_NS = 10;
   localparam int DATA_SETUP_TO_WRITE_END_NS = 10;
   localparam int WRITE_HOLD_AFTER_CONTENTION_NS = 12;
   localparam int CONTENTION_WINDOW_NS = 5;
   localparam int WRITE_PULSE_TO_DATA_NS = 30;
   localparam int WRITE_DATA_TO_READ_DATA_DELAY_NS = 25;
   localparam int READ_ACCESS_NS = 35;
   // Cycle counts: least times round up
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int WP_PLAIN_CYC = cyc_up(WRITE_PULSE_NS);
   localparam int WP_OE_CYC = cyc_up((WRITE_PULSE_NS > OUTPUT_OFF_NS + DATA_SETUP_TO_WRITE_END_NS) ?
                                     WRITE_PULSE_NS : OUTPUT_OFF_NS + DATA_SETUP_TO_WRITE_END_NS);
   localparam int HOLD_CYC = cyc_up(WRITE_HOLD_AFTER_CONTENTION_NS);
   localparam int SEP_CYC = cyc_up(CONTENTION_WINDOW_NS);
   localparam int RD_CYC = cyc_up(READ_ACCESS_NS + WRITE_PULSE_TO_DATA_NS);
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [DATA_W-1:0] FLAG_FREE = 8'hff;
   localparam logic [DATA_W-1:0] FLAG_TAKE = 8'h00;
   typedef enum logic [1:0] {DPA_RD_MEM, DPA_WR_MEM, DPA_RD_FLAG, DPA_WR_FLAG} dpa_op_t;
   typedef struct packed {
      dpa_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } dpa_req_t;
   typedef struct packed {
      logic chip_select_n;
      logic flag_select_n;
      logic write_n;
      logic output_enable_n;
      logic [ADDR_W-1:0] addr;
   } dpa_pins_t;
endpackage

// ===== dpa_host.sv
// Host controller for one port of an asynchronous dual-port RAM.
// Assumes device pins synchronous to clk; contention pin is an input here.
`timescale 1ns/1ps
// Contract
// RULE1: Device writes only during overlap of low select and low strobe.
// RULE2: Host keeps strobe high whenever address changes.
// RULE3: Memory: select low, flag high; flag: reverse; held through write.
// RULE4: Select falling with or after strobe keeps device outputs off.
// RULE5: With output enable low, pulse is max of width or turn-off plus setup.
// RULE6: Host never drives data while device outputs may be on.
// RULE7: Flag read drives all eight data lines to the flag value.
// RULE8: A free flag reads all ones from both ports.
// RULE9: Near-simultaneous flag requests grant exactly one port.
// RULE10: Master mode gives priority to earlier valid port.
// RULE11: Slave mode does no arbitration of its own.
// RULE12: Losing port busy follows address match in master mode.
// RULE13: Busy follows later chip select with matching addresses.
// RULE14: External logic drives busy low by start of write strobe.
// RULE15: Held-off write keeps strobe low the hold time after busy rises.
// RULE16: Device blocks strobe while busy is asserted.
// RULE17: Written data reaches other port within port-to-port delays.
// RULE18: Busy release to data is the max of three values.
// RULE19: Slave busy input inhibits writes internally.
// RULE20: Master ignores writes on a port whose busy it drives low.
// RULE21: Flag requests from two ports separated by the contention window.
module dpa_host (
   input wire logic clk,
   input wire logic rst_n,
   input wire dpa_pkg::dpa_req_t req,
   input wire logic req_valid,
   output logic req_ready,
   output logic [dpa_pkg::DATA_W-1:0] rsp_data,
   output logic rsp_valid,
   output dpa_pkg::dpa_pins_t pins,
   output logic [dpa_pkg::DATA_W-1:0] data_out,
   output logic data_oe_n,
   input wire logic [dpa_pkg::DATA_W-1:0] data_in,
   input wire logic contention_n
);
   typedef enum logic [2:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_READ, S_GAP} dpa_state_t;
   dpa_state_t state_q;
   dpa_pkg::dpa_req_t cur_q;
   logic [3:0] cnt_q;
   logic busy_seen_q;
   logic contention_n_q;

   function automatic logic is_write(input dpa_pkg::dpa_op_t op);
      return (op == dpa_pkg::DPA_WR_MEM) || (op == dpa_pkg::DPA_WR_FLAG);
   endfunction
   function automatic logic is_flag(input dpa_pkg::dpa_op_t op);
      return (op == dpa_pkg::DPA_RD_FLAG) || (op == dpa_pkg::DPA_WR_FLAG);
   endfunction

   // ==========================================================
   // Busy input register
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         contention_n_q <= 1'b1;
      end else begin
         contention_n_q <= contention_n; // RULE14
      end
   end

   // ==========================================================
   // Sequencer
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         cur_q <= '0;
         cnt_q <= 4'h0;
         busy_seen_q <= 1'b0;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (req_valid) begin
                  cur_q <= req;
                  state_q <= S_SETUP;
                  busy_seen_q <= 1'b0;
               end
            end
            S_SETUP: begin
               // Address settles with strobe high; outputs off first for writes
               state_q <= is_write(cur_q.op) ? S_PULSE : S_READ; // RULE2
               cnt_q <= is_write(cur_q.op) ? 4'(dpa_pkg::WP_OE_CYC) : 4'(dpa_pkg::RD_CYC); // RULE5
            end
            S_PULSE: begin
               if (!contention_n_q) begin
                  busy_seen_q <= 1'b1;
                  cnt_q <= 4'(dpa_pkg::HOLD_CYC); // RULE15
               end else if (cnt_q == dpa_pkg::CNT_ONE) begin
                  state_q <= S_HOLD;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            S_HOLD: begin
               state_q <= S_GAP;
               cnt_q <= 4'(dpa_pkg::SEP_CYC); // RULE21
            end
            S_READ: begin
               if (cnt_q == dpa_pkg::CNT_ONE) begin
                  state_q <= S_GAP;
                  cnt_q <= 4'(dpa_pkg::SEP_CYC);
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            S_GAP: begin
               if (cnt_q == dpa_pkg::CNT_ONE) begin
                  state_q <= S_IDLE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Pin drive
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pins <= '{chip_select_n: 1'b1, flag_select_n: 1'b1, write_n: 1'b1, output_enable_n: 1'b1,
                   addr: '0};
         data_out <= '0;
         data_oe_n <= 1'b1;
      end else begin
         if (state_q == S_IDLE && req_valid) begin
            pins.addr <= req.addr;
            // Select only one target at a time
            pins.chip_select_n <= is_flag(req.op); // RULE3
            pins.flag_select_n <= !is_flag(req.op); // RULE3
            pins.output_enable_n <= is_write(req.op);
         end else if (state_q == S_SETUP && is_write(cur_q.op)) begin
            pins.write_n <= 1'b0; // RULE1
            data_out <= is_flag(cur_q.op) ? cur_q.data & 8'h01 : cur_q.data;
            data_oe_n <= 1'b0; // RULE6
         end else if (state_q == S_HOLD || (state_q == S_READ && cnt_q == dpa_pkg::CNT_ONE)) begin
            pins.write_n <= 1'b1;
            pins.chip_select_n <= 1'b1;
            pins.flag_select_n <= 1'b1;
            pins.output_enable_n <= 1'b1;
            data_oe_n <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Request and answer
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= '0;
      end else begin
         req_ready <= (state_q == S_GAP && cnt_q == dpa_pkg::CNT_ONE);
         rsp_valid <= 1'b0;
         if (state_q == S_READ && cnt_q == dpa_pkg::CNT_ONE) begin
            // Flag reads are collapsed to bit 0; all lines carry the flag
            rsp_data <= is_flag(cur_q.op) ? {dpa_pkg::DATA_W{data_in[0]}} : data_in; // RULE7
            rsp_valid <= 1'b1;
         end else if (state_q == S_HOLD) begin
            rsp_data <= cur_q.data;
            rsp_valid <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   property p_addr_stable;
      @(posedge clk) disable iff (!rst_n)
      !pins.write_n |-> $stable(pins.addr);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("Address moved during write"); // RULE2

   property p_one_target;
      @(posedge clk) disable iff (!rst_n)
      !(pins.chip_select_n == 1'b0 && pins.flag_select_n == 1'b0);
   endproperty
   a_one_target: assert property (p_one_target) else $error("Both selects low"); // RULE3

   property p_no_fight;
      @(posedge clk) disable iff (!rst_n)
      !data_oe_n |-> pins.output_enable_n;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("Data driven with device outputs on"); // RULE6

   sequence s_strobe_fall;
      pins.write_n ##1 !pins.write_n;
   endsequence
   property p_pulse_width;
      @(posedge clk) disable iff (!rst_n)
      s_strobe_fall |=> !pins.write_n;
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("Write pulse too short"); // RULE5

   property p_hold_after_busy;
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_PULSE && $rose(contention_n_q)) |-> !pins.write_n;
   endproperty
   a_hold_after_busy: assert property (p_hold_after_busy) else $error("Strobe released at busy rise"); // RULE15

   property p_gap;
      @(posedge clk) disable iff (!rst_n)
      $rose(pins.write_n) |-> (state_q == S_GAP);
   endproperty
   a_gap: assert property (p_gap) else $error("No gap after write"); // RULE21

   property p_target_held;
      @(posedge clk) disable iff (!rst_n)
      !pins.write_n |-> $stable({pins.chip_select_n, pins.flag_select_n});
   endproperty
   a_target_held: assert property (p_target_held) else $error("Target changed during write"); // RULE3

   // Strobe must outlast busy release by at least two samples
   property p_busy_hold;
      @(posedge clk) disable iff (!rst_n)
      (busy_seen_q && $rose(pins.write_n)) |-> $past(contention_n_q, 2);
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("Strobe released too soon after busy"); // RULE15
endmodule

// ===== dpa_ram_model.sv
// Behavioural model of one port of the dual-port RAM, sampled on clk.
// Assumes the host pins of dpa_host and a contention input from the bench.
`timescale 1ns/1ps
module dpa_ram_model (
   input wire logic clk,
   input wire dpa_pkg::dpa_pins_t pins,
   input wire logic [dpa_pkg::DATA_W-1:0] data_out,
   input wire logic data_oe_n,
   input wire logic contention_n,
   output logic [dpa_pkg::DATA_W-1:0] data_in
);
   logic [7:0] mem [0:16383];
   logic [7:0] flag_q = 8'hff;
   logic [7:0] idle_q = 8'h5a;
   logic rd_mem;
   logic rd_flag;
   // ==========
   // Writes
   always @(posedge clk) begin
      idle_q <= ~idle_q;
      // Low contention inhibits the write internally
      if (!pins.write_n && contention_n) begin
         if (!pins.chip_select_n && pins.flag_select_n) begin
            // Undriven bus stores junk, so a host that never drives is caught
            mem[pins.addr] <= data_oe_n ? idle_q : data_out;
         end
         if (pins.chip_select_n && !pins.flag_select_n) begin
            flag_q[pins.addr[2:0]] <= data_oe_n ? idle_q[0] : data_out[0];
         end
      end
   end
   // ==========
   // Reads; a released bus shows a toggling pattern, never stale data
   assign rd_mem = !pins.chip_select_n && pins.flag_select_n && !pins.output_enable_n && pins.write_n;
   assign rd_flag = pins.chip_select_n && !pins.flag_select_n && !pins.output_enable_n && pins.write_n;
   assign data_in = rd_mem ? mem[pins.addr] : rd_flag ? {8{flag_q[pins.addr[2:0]]}} : idle_q;
endmodule

// ===== tb_top.sv
// Self-checking bench for dpa_host against the RAM port model.
// Assumes the 20 MHz clock and the transfer walk of the host.
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   logic contention_n = 1'b1;
   dpa_pkg::dpa_req_t req = '0;
   logic req_ready, rsp_valid, data_oe_n;
   logic [7:0] rsp_data, data_out, data_in, d;
   logic [13:0] a;
   logic [7:0] mv, rv;
   dpa_pkg::dpa_pins_t pins, prev_pins;
   int n_errors = 0;
   int comparisons = 0;
   int seed = 70116;
   always #25 clk = ~clk;
   dpa_host dpa_host_i (.clk(clk), .rst_n(rst_n), .req(req), .req_valid(req_valid), .req_ready(req_ready),
      .rsp_data(rsp_data), .rsp_valid(rsp_valid), .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n),
      .data_in(data_in), .contention_n(contention_n));
   dpa_ram_model dpa_ram_model_i (.clk(clk), .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n),
      .contention_n(contention_n), .data_in(data_in));
   // ==========
   // Checking
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s saw %h want %h", $time, what, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      #1;
      if (rst_n) begin
         if (pins.addr !== prev_pins.addr) begin
            mv = {6'h0, pins.write_n | pins.chip_select_n, prev_pins.write_n | prev_pins.chip_select_n};
            check(mv, 8'h03, "address moved in write");
         end
         check({7'h0, pins.chip_select_n | pins.flag_select_n}, 8'h01, "both selects low");
         check({7'h0, data_oe_n | pins.output_enable_n}, 8'h01, "bus fight");
      end
      prev_pins = pins;
   end
   // ==========
   // One transfer; busy holds contention low one cycle more than that many cycles
   task automatic op(input dpa_pkg::dpa_op_t o, input logic [13:0] ad, input logic [7:0] dt,
      input logic [7:0] exp, input int busy);
      int n;
      @(posedge clk);
      req <= '{op: o, addr: ad, data: dt};
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      if (busy > 0) begin
         // Busy stands for the far port's arbitration outcome
         contention_n <= 1'b0;
         repeat (busy) begin
            @(posedge clk);
            #1 check({7'h0, rsp_valid}, 8'h00, "done under busy");
         end
         @(posedge clk);
         contention_n <= 1'b1;
         @(posedge clk);
         #1 check({7'h0, pins.write_n}, 8'h00, "strobe dropped at release");
      end
      n = 0;
      while (rsp_valid !== 1'b1) begin
         @(posedge clk);
         #1 n++;
         if (n > 40) begin
            n_errors++;
            print_verdict();
         end
      end
      check(rsp_data, exp, "response");
      repeat (2) @(posedge clk);
   endtask
   // ==========
   // Sequence
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      #1 rv = {4'h0, pins.chip_select_n, pins.flag_select_n, pins.write_n, pins.output_enable_n};
      check(rv, 8'h0f, "reset");
      op(dpa_pkg::DPA_WR_MEM, 14'h0000, 8'ha5, 8'ha5, 0);
      op(dpa_pkg::DPA_WR_MEM, 14'h3fff, 8'h5a, 8'h5a, 0);
      op(dpa_pkg::DPA_RD_MEM, 14'h0000, 8'h00, 8'ha5, 0);
      op(dpa_pkg::DPA_RD_MEM, 14'h3fff, 8'h00, 8'h5a, 0);
      for (int i = 0; i < 8; i++) begin
         a = 14'($random(seed));
         d = 8'($random(seed));
         op(dpa_pkg::DPA_WR_MEM, a, d, d, 0);
         op(dpa_pkg::DPA_WR_MEM, a, ~d, ~d, 0);
         op(dpa_pkg::DPA_RD_MEM, a, 8'h00, ~d, 0);
      end
      $display("test memory done");
      op(dpa_pkg::DPA_RD_FLAG, 14'h0000, 8'h00, 8'hff, 0);
      op(dpa_pkg::DPA_WR_FLAG, 14'h0000, 8'h00, 8'h00, 0);
      op(dpa_pkg::DPA_RD_FLAG, 14'h0000, 8'h00, 8'h00, 0);
      op(dpa_pkg::DPA_RD_FLAG, 14'h0001, 8'h00, 8'hff, 0);
      op(dpa_pkg::DPA_WR_FLAG, 14'h0000, 8'h01, 8'h01, 0);
      op(dpa_pkg::DPA_RD_FLAG, 14'h0000, 8'h00, 8'hff, 0);
      $display("test flags done");
      op(dpa_pkg::DPA_WR_MEM, 14'h0123, 8'h3c, 8'h3c, 4);
      op(dpa_pkg::DPA_RD_MEM, 14'h0123, 8'h00, 8'h3c, 0);
      $display("test contention done");
      print_verdict();
   end
endmodule
